// ===== shared/tws_pkg.sv
// constants, register map and state type for the two-wire slave receiver
package tws_pkg;
  // register byte offsets on the apb side
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ADDR = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_DATA = 8'h0C;
  // serial_control bit positions
  localparam int CB_FLAG = 7;
  localparam int CB_ACK = 6;
  localparam int CB_STA = 5;
  localparam int CB_STO = 4;
  localparam int CB_WC = 3;
  localparam int CB_EN = 2;
  localparam int CB_IE = 0;
  // own_slave_address layout
  localparam int AB_GCE = 0;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  // status codes, prescaler bits always zero
  localparam logic [7:0] ST_NONE = 8'hF8;
  localparam logic [7:0] ST_OWN_ACK = 8'h60;
  localparam logic [7:0] ST_ARB_OWN = 8'h68;
  localparam logic [7:0] ST_GC_ACK = 8'h70;
  localparam logic [7:0] ST_ARB_GC = 8'h78;
  localparam logic [7:0] ST_OWN_DATA = 8'h80;
  localparam logic [7:0] ST_OWN_NACK = 8'h88;
  localparam logic [7:0] ST_GC_DATA = 8'h90;
  localparam logic [7:0] ST_GC_NACK = 8'h98;
  localparam logic [2:0] ST_PRESC_MASK = 3'h7;
  // bus constants
  localparam logic [6:0] GC_ADDR = 7'h00;
  localparam logic RW_WRITE = 1'b0;
  localparam logic [2:0] LAST_BIT = 3'h7;
  typedef enum logic [2:0] {
    TWS_IDLE = 3'b000,
    TWS_ADDR = 3'b001,
    TWS_DATA = 3'b011,
    TWS_ACKF = 3'b010,
    TWS_ACKD = 3'b110,
    TWS_HOLD = 3'b111
  } tws_state_t;
endpackage

// ===== rtl/tws_line_mon.sv
// bus line synchroniser with edge, start and stop detection
module tws_line_mon (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // raw bus levels
  input wire logic scl_in,
  input wire logic sda_in,
  // synchronised levels and events
  output logic scl_s,
  output logic sda_s,
  output logic scl_rise,
  output logic scl_fall,
  output logic start_det,
  output logic stop_det
);
  logic scl_m_r;
  logic sda_m_r;
  logic scl_s_r;
  logic sda_s_r;
  logic scl_d_r;
  logic sda_d_r;

  // idle bus is high, so the flops reset to one
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      scl_m_r <= 1'b1;
      sda_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      sda_s_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end
    else
    begin
      scl_m_r <= scl_in;
      sda_m_r <= sda_in;
      scl_s_r <= scl_m_r;
      sda_s_r <= sda_m_r;
      scl_d_r <= scl_s_r;
      sda_d_r <= sda_s_r;
    end
  end

  assign scl_s = scl_s_r;
  assign sda_s = sda_s_r;
  assign scl_rise = scl_s_r & ~scl_d_r;
  assign scl_fall = ~scl_s_r & scl_d_r;
  // sda moving while scl stays high marks start or stop
  assign start_det = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
  assign stop_det = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;
endmodule

// ===== rtl/tws_slave_rx.sv
// two-wire slave receiver with apb register access
// What this block does
// - upper seven address bits are own address
// - address lsb enables general call answer
// - write direction enters receive, read does not
// - address plus write sets flag and status
// - lost arbitration reports 0x68 or 0x78
// - cleared ack enable gives nack next byte
// - no ack enable, no address answer
// - sleeping, still match address and wake
// - hold scl low until flag cleared
// - data register not loaded while asleep
// - own address write acked reports 0x60
// - general call acked reports 0x70
// - data acked reports 0x80 or 0x90
// - flag clear receives next byte, ack per enable
// - nacked data 0x88/0x98 then not addressed
// - re-match needs ack enable, gc enable
// - start request written with the flag clear that leaves addressed mode issues start when bus free
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
module tws_slave_rx #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // bus pins, open drain
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // system side
  input wire logic sleep_deep,
  input wire logic arb_lost,
  output logic wake_req,
  output logic start_issue
);
  tws_pkg::tws_state_t state_r;
  tws_pkg::tws_state_t state_nxt;
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic flag_r;
  logic ack_en_r;
  logic sta_r;
  logic sto_r;
  logic wc_r;
  logic en_r;
  logic ie_r;
  logic [7:0] own_addr_r;
  logic [7:0] status_r;
  logic [7:0] data_r;
  logic [31:0] prdata_r;
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic [7:0] shift_r;
  logic [7:0] shift_nxt;
  logic gc_r;
  logic gc_nxt;
  logic arb_r;
  logic arb_nxt;
  logic ack_bit_r;
  logic ack_bit_nxt;
  logic addr_byte_r;
  logic addr_byte_nxt;
  logic sda_oe_r;
  logic sda_oe_nxt;
  logic wake_r;
  logic start_pend_r;
  logic start_pend_nxt;
  logic bus_free_r;
  logic start_issue_r;
  logic flag_set;
  logic load_data;

  tws_line_mon u_mon (
    .pclk(pclk),
    .presetn(presetn),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .scl_s(scl_s),
    .sda_s(sda_s),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_det(start_det),
    .stop_det(stop_det)
  );

  // apb decode, zero wait states
  wire setup_ph = psel & ~penable;
  wire acc_wr = psel & penable & pwrite;
  wire sel_ctrl = (paddr == ADDR_W'(tws_pkg::OFF_CTRL));
  wire sel_addr = (paddr == ADDR_W'(tws_pkg::OFF_ADDR));
  wire sel_stat = (paddr == ADDR_W'(tws_pkg::OFF_STAT));
  wire sel_data = (paddr == ADDR_W'(tws_pkg::OFF_DATA));
  wire hit = sel_ctrl | sel_addr | sel_stat | sel_data;
  wire wr_ctrl = acc_wr & sel_ctrl;
  wire wr_addr = acc_wr & sel_addr;
  wire wr_data = acc_wr & sel_data;
  wire sw_clr = wr_ctrl & pwdata[tws_pkg::CB_FLAG];
  wire [7:0] ctrl_rd = {flag_r, ack_en_r, sta_r, sto_r, wc_r, en_r, 1'b0, ie_r};
  wire [7:0] rd_byte = sel_ctrl ? ctrl_rd :
                       sel_addr ? own_addr_r :
                       sel_stat ? status_r :
                       sel_data ? data_r : 8'h00;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata = prdata_r;

  // incoming byte and address matching
  wire [7:0] byte_in = {shift_r[6:0], sda_s};
  wire byte_done = scl_rise & (cnt_r == tws_pkg::LAST_BIT);
  wire own_hit = ack_en_r & (byte_in[7:1] == own_addr_r[7:1]);
  wire gc_hit = ack_en_r & own_addr_r[tws_pkg::AB_GCE]
                & (byte_in[7:1] == tws_pkg::GC_ADDR);
  wire wr_dir = (byte_in[0] == tws_pkg::RW_WRITE);
  // general call and own address share the code table layout
  wire [7:0] addr_code = gc_r ? (arb_r ? tws_pkg::ST_ARB_GC : tws_pkg::ST_GC_ACK)
                              : (arb_r ? tws_pkg::ST_ARB_OWN : tws_pkg::ST_OWN_ACK);
  wire [7:0] data_code = gc_r ? (ack_bit_r ? tws_pkg::ST_GC_DATA : tws_pkg::ST_GC_NACK)
                              : (ack_bit_r ? tws_pkg::ST_OWN_DATA : tws_pkg::ST_OWN_NACK);
  wire [7:0] st_code = (addr_byte_r ? addr_code : data_code)
                       & {5'h1F, ~tws_pkg::ST_PRESC_MASK};

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    shift_nxt = shift_r;
    gc_nxt = gc_r;
    arb_nxt = arb_r;
    ack_bit_nxt = ack_bit_r;
    addr_byte_nxt = addr_byte_r;
    sda_oe_nxt = sda_oe_r;
    start_pend_nxt = start_pend_r;
    flag_set = 1'b0;
    load_data = 1'b0;
    case (state_r)
      tws_pkg::TWS_ADDR, tws_pkg::TWS_DATA:
      begin
        if (scl_rise)
        begin
          shift_nxt = byte_in;
          cnt_nxt = cnt_r + 3'h1;
        end
        if (byte_done && state_r == tws_pkg::TWS_ADDR)
        begin
          if (wr_dir && (own_hit || gc_hit))
          begin
            state_nxt = tws_pkg::TWS_ACKF;
            ack_bit_nxt = 1'b1;
            gc_nxt = ~own_hit;
            arb_nxt = arb_lost;
            addr_byte_nxt = 1'b1;
            load_data = ~sleep_deep;
          end
          else
          begin
            state_nxt = tws_pkg::TWS_IDLE;
          end
        end
        else if (byte_done)
        begin
          state_nxt = tws_pkg::TWS_ACKF;
          ack_bit_nxt = ack_en_r;
          addr_byte_nxt = 1'b0;
          load_data = ~sleep_deep;
        end
      end
      tws_pkg::TWS_ACKF:
      begin
        if (scl_fall)
        begin
          state_nxt = tws_pkg::TWS_ACKD;
          sda_oe_nxt = ack_bit_r;
        end
      end
      tws_pkg::TWS_ACKD:
      begin
        if (scl_fall)
        begin
          state_nxt = tws_pkg::TWS_HOLD;
          sda_oe_nxt = 1'b0;
          flag_set = 1'b1;
        end
      end
      tws_pkg::TWS_HOLD:
      begin
        if (sw_clr)
        begin
          cnt_nxt = 3'h0;
          if (!ack_bit_r || pwdata[tws_pkg::CB_STO])
          begin
            state_nxt = tws_pkg::TWS_IDLE;
            start_pend_nxt = pwdata[tws_pkg::CB_STA];
          end
          else
          begin
            state_nxt = tws_pkg::TWS_DATA;
          end
        end
      end
      default:
      begin
        state_nxt = tws_pkg::TWS_IDLE;
      end
    endcase
    // framing events override the byte engine, except while stretching
    if (start_det && state_r != tws_pkg::TWS_HOLD)
    begin
      state_nxt = tws_pkg::TWS_ADDR;
      cnt_nxt = 3'h0;
      sda_oe_nxt = 1'b0;
    end
    else if (stop_det && state_r != tws_pkg::TWS_HOLD)
    begin
      state_nxt = tws_pkg::TWS_IDLE;
      sda_oe_nxt = 1'b0;
    end
    if (!en_r)
    begin
      state_nxt = tws_pkg::TWS_IDLE;
      sda_oe_nxt = 1'b0;
      flag_set = 1'b0;
      load_data = 1'b0;
    end
    if (start_pend_r && bus_free_r)
    begin
      start_pend_nxt = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= tws_pkg::TWS_IDLE;
      cnt_r <= 3'h0;
      shift_r <= 8'h00;
      gc_r <= 1'b0;
      arb_r <= 1'b0;
      ack_bit_r <= 1'b0;
      addr_byte_r <= 1'b0;
      sda_oe_r <= 1'b0;
      start_pend_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      gc_r <= gc_nxt;
      arb_r <= arb_nxt;
      ack_bit_r <= ack_bit_nxt;
      addr_byte_r <= addr_byte_nxt;
      sda_oe_r <= sda_oe_nxt;
      start_pend_r <= start_pend_nxt;
    end
  end

  // control bits; a hardware set beats a same-cycle software clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flag_r <= tws_pkg::CTRL_RST[tws_pkg::CB_FLAG];
      ack_en_r <= tws_pkg::CTRL_RST[tws_pkg::CB_ACK];
      sta_r <= tws_pkg::CTRL_RST[tws_pkg::CB_STA];
      sto_r <= tws_pkg::CTRL_RST[tws_pkg::CB_STO];
      en_r <= tws_pkg::CTRL_RST[tws_pkg::CB_EN];
      ie_r <= tws_pkg::CTRL_RST[tws_pkg::CB_IE];
    end
    else
    begin
      flag_r <= flag_set | (flag_r & ~sw_clr);
      if (wr_ctrl)
      begin
        ack_en_r <= pwdata[tws_pkg::CB_ACK];
        sta_r <= pwdata[tws_pkg::CB_STA];
        sto_r <= pwdata[tws_pkg::CB_STO];
        en_r <= pwdata[tws_pkg::CB_EN];
        ie_r <= pwdata[tws_pkg::CB_IE];
      end
      else if (sto_r)
      begin
        sto_r <= 1'b0;
      end
    end
  end

  // data, address, status and collision registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      own_addr_r <= tws_pkg::ADDR_RST;
      data_r <= tws_pkg::DATA_RST;
      status_r <= tws_pkg::ST_NONE;
      wc_r <= 1'b0;
    end
    else
    begin
      if (wr_addr)
        own_addr_r <= pwdata[7:0];
      if (load_data)
        data_r <= byte_in;
      else if (wr_data && flag_r)
        data_r <= pwdata[7:0];
      if (flag_set)
        status_r <= st_code;
      else if (sw_clr)
        status_r <= tws_pkg::ST_NONE;
      // writing data while the bus owns it is a collision
      if (wr_data)
        wc_r <= ~flag_r;
    end
  end

  // sleep wake, bus-free tracking and read data capture
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wake_r <= 1'b0;
      bus_free_r <= 1'b1;
      start_issue_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end
    else
    begin
      if (flag_set && addr_byte_r && sleep_deep)
        wake_r <= 1'b1;
      else if (sw_clr)
        wake_r <= 1'b0;
      if (start_det)
        bus_free_r <= 1'b0;
      else if (stop_det)
        bus_free_r <= 1'b1;
      start_issue_r <= start_pend_r & bus_free_r;
      // captured in setup so the access phase sees stable data
      if (setup_ph)
        prdata_r <= {24'h00_0000, rd_byte};
    end
  end

  assign scl_oe = (state_r == tws_pkg::TWS_HOLD);
  assign scl_out = 1'b0;
  assign sda_oe = sda_oe_r;
  assign sda_out = 1'b0;
  assign wake_req = wake_r;
  assign start_issue = start_issue_r;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  hold_flag_a: assert property (state_r == tws_pkg::TWS_HOLD |-> flag_r && scl_oe)
    else $error("scl not held with flag set");
  release_a: assert property ($fell(flag_r) |-> !scl_oe)
    else $error("scl still held after flag clear");
  own_code_a: assert property ($rose(flag_r) && addr_byte_r && !gc_r && !arb_r
    |-> status_r == tws_pkg::ST_OWN_ACK)
    else $error("own address status wrong");
  gc_code_a: assert property ($rose(flag_r) && addr_byte_r && gc_r && !arb_r
    |-> status_r == tws_pkg::ST_GC_ACK)
    else $error("general call status wrong");
  arb_code_a: assert property ($rose(flag_r) && addr_byte_r && arb_r
    |-> status_r == (gc_r ? tws_pkg::ST_ARB_GC : tws_pkg::ST_ARB_OWN))
    else $error("arbitration status wrong");
  data_code_a: assert property ($rose(flag_r) && !addr_byte_r
    |-> status_r[7:4] == (gc_r ? 4'h9 : 4'h8) && status_r[3] == !ack_bit_r)
    else $error("data status wrong");
  presc_zero_a: assert property (status_r[2:0] == 3'h0)
    else $error("prescaler bits not zero");
  nack_drive_a: assert property (state_r == tws_pkg::TWS_ACKD && !ack_bit_r |-> !sda_oe)
    else $error("sda driven on nack");
  no_ack_a: assert property (state_r == tws_pkg::TWS_ADDR && byte_done && !ack_en_r
    |=> state_r != tws_pkg::TWS_ACKF)
    else $error("address acked with ack disabled");
  nack_leave_a: assert property (state_r == tws_pkg::TWS_HOLD && !ack_bit_r && sw_clr
    |=> state_r == tws_pkg::TWS_IDLE ##1 !flag_r)
    else $error("nack did not leave addressed mode");
  wake_a: assert property ($rose(wake_r) |-> flag_r && scl_oe)
    else $error("wake without flag");

  own_c: cover property ($rose(flag_r) && status_r == tws_pkg::ST_OWN_ACK);
  gc_c: cover property ($rose(flag_r) && status_r == tws_pkg::ST_GC_DATA);
  nack_c: cover property ($rose(flag_r) && status_r == tws_pkg::ST_OWN_NACK);
  wake_c: cover property ($rose(wake_r));
endmodule

// ===== tb/tws_bus_master.sv
// behavioural two-wire bus master transmitter facing the slave receiver
module tws_bus_master (
  // clock
  input wire logic pclk,
  // bus line levels
  input wire logic scl,
  input wire logic sda,
  // open-drain pulls, high pulls the line low
  output logic scl_low,
  output logic sda_low,
  // a clock stretch outlasted the wait bound
  output logic stall_err
);
  timeunit 1ns;
  timeprecision 1ns;
  // 400 ns link period at 40 ns system clock
  localparam int HALF = 4;
  initial
  begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    stall_err = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // sda moves only a cycle after scl is low, never next to a high scl
  task automatic clk_bit(input logic b, output logic seen);
    int n;
    n = 0;
    hold(1);
    sda_low <= !b;
    hold(HALF);
    scl_low <= 1'b0;
    @(posedge pclk);
    while (scl !== 1'b1 && n < 3000)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 3000)
      stall_err <= 1'b1;
    hold(2);
    seen = sda;
    hold(2);
    scl_low <= 1'b1;
  endtask
  task automatic start;
    sda_low <= 1'b1;
    hold(HALF);
    scl_low <= 1'b1;
  endtask
  // msb first, then the ninth bit released for the slave's answer
  task automatic send(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      clk_bit(v[i], s);
    clk_bit(1'b1, s);
    ack = !s;
  endtask
  task automatic stop;
    hold(1);
    sda_low <= 1'b1;
    hold(HALF);
    scl_low <= 1'b0;
    hold(HALF);
    sda_low <= 1'b0;
    hold(HALF);
  endtask
endmodule

// ===== tb/test_tws_slave_rx.sv
// self-checking bench for the two-wire slave receiver
module test_tws_slave_rx;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, sleep_deep, arb_lost;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic pready, pslverr, scl_oe, sda_oe, scl_out, sda_out, wake_req, start_issue;
  logic scl_low, sda_low, stall_err, e, ack;
  logic [6:0] own;
  logic [7:0] d;
  logic [7:0] codes [4];
  int miscompares, check_count, starts;
  // pull-ups: a released line reads high
  wire logic scl = !(scl_low | scl_oe);
  wire logic sda = !(sda_low | sda_oe);
  tws_slave_rx #(.ADDR_W(8)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .sleep_deep(sleep_deep),
    .arb_lost(arb_lost), .wake_req(wake_req), .start_issue(start_issue));
  tws_bus_master m (.pclk(pclk), .scl(scl), .sda(sda), .scl_low(scl_low),
    .sda_low(sda_low), .stall_err(stall_err));
  always #20 pclk = !pclk;
  // one-cycle pulse, so counted on every edge
  always @(posedge pclk)
    if (start_issue === 1'b1)
      starts++;
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string w);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] v);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, v};
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 50)
    begin
      miscompares++;
      results();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x, input string w);
    apb(1'b0, a, 8'h00);
    check(q[7:0], x, w);
  endtask
  // the flag lands a few cycles after the last scl fall, so poll for it
  task automatic wait_flag;
    int n;
    n = 0;
    q = 32'h0;
    while (q[7] !== 1'b1 && n < 100)
    begin
      apb(1'b0, tws_pkg::OFF_CTRL, 8'h00);
      n++;
    end
    if (n >= 100)
    begin
      miscompares++;
      $display("[ERR] %0t flag never set", $time);
      results();
    end
  endtask
  task automatic addr_cyc(input logic [7:0] b, input logic xa, input logic [7:0] xs);
    m.start();
    m.send(b, ack);
    check({7'h0, ack}, {7'h0, xa}, "address ack");
    if (xa)
      wait_flag();
    rd(tws_pkg::OFF_STAT, xs, "address status");
  endtask
  task automatic data_cyc(input logic xa, input logic [7:0] xs);
    d = 8'($urandom);
    m.send(d, ack);
    check({7'h0, ack}, {7'h0, xa}, "data ack");
    wait_flag();
    rd(tws_pkg::OFF_STAT, xs, "data status");
    rd(tws_pkg::OFF_DATA, d, "data byte");
  endtask
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, sleep_deep, arb_lost} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    miscompares = 0;
    check_count = 0;
    starts = 0;
    codes = '{tws_pkg::ST_OWN_ACK, tws_pkg::ST_GC_ACK, tws_pkg::ST_ARB_OWN, tws_pkg::ST_ARB_GC};
    void'($urandom(67304));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    rd(tws_pkg::OFF_CTRL, tws_pkg::CTRL_RST, "ctrl reset");
    rd(tws_pkg::OFF_ADDR, tws_pkg::ADDR_RST, "addr reset");
    rd(tws_pkg::OFF_STAT, tws_pkg::ST_NONE, "status reset");
    apb(1'b0, 8'h10, 8'h00);
    check({7'h0, e}, 8'h01, "unmapped error");
    $display("test reset done");
    own = 7'(($urandom % 126) + 1);
    apb(1'b1, tws_pkg::OFF_ADDR, {own, 1'b1});
    apb(1'b1, tws_pkg::OFF_CTRL, 8'h44);
    addr_cyc({own, 1'b0}, 1'b1, tws_pkg::ST_OWN_ACK);
    rd(tws_pkg::OFF_CTRL, 8'hC4, "flag set");
    check({7'h0, scl_oe}, 8'h01, "scl held");
    repeat (3)
    begin
      apb(1'b1, tws_pkg::OFF_CTRL, 8'hC4);
      data_cyc(1'b1, tws_pkg::ST_OWN_DATA);
    end
    apb(1'b1, tws_pkg::OFF_CTRL, 8'h84);
    data_cyc(1'b0, tws_pkg::ST_OWN_NACK);
    apb(1'b1, tws_pkg::OFF_CTRL, 8'hA4);
    m.stop();
    repeat (20) @(posedge pclk);
    check({7'h0, starts > 0}, 8'h01, "start issued");
    apb(1'b1, tws_pkg::OFF_CTRL, 8'h04);
    addr_cyc({own, 1'b0}, 1'b0, tws_pkg::ST_NONE);
    m.stop();
    $display("test own address done");
    apb(1'b1, tws_pkg::OFF_CTRL, 8'h44);
    addr_cyc(8'h00, 1'b1, tws_pkg::ST_GC_ACK);
    apb(1'b1, tws_pkg::OFF_CTRL, 8'hC4);
    data_cyc(1'b1, tws_pkg::ST_GC_DATA);
    apb(1'b1, tws_pkg::OFF_CTRL, 8'h84);
    data_cyc(1'b0, tws_pkg::ST_GC_NACK);
    apb(1'b1, tws_pkg::OFF_CTRL, 8'hC4);
    m.stop();
    addr_cyc({own, 1'b1}, 1'b0, tws_pkg::ST_NONE);
    m.stop();
    $display("test general call done");
    for (int i = 0; i < 4; i++)
    begin
      arb_lost <= i[1];
      addr_cyc(i[0] ? 8'h00 : {own, 1'b0}, 1'b1, codes[i]);
      apb(1'b1, tws_pkg::OFF_CTRL, 8'hC4);
      m.stop();
    end
    arb_lost <= 1'b0;
    apb(1'b1, tws_pkg::OFF_ADDR, {own, 1'b0});
    addr_cyc(8'h00, 1'b0, tws_pkg::ST_NONE);
    m.stop();
    $display("test arbitration done");
    sleep_deep <= 1'b1;
    addr_cyc({own, 1'b0}, 1'b1, tws_pkg::ST_OWN_ACK);
    check({7'h0, wake_req}, 8'h01, "wake");
    // last byte loaded awake was the general call address of the arbitration loop
    rd(tws_pkg::OFF_DATA, 8'h00, "data kept");
    check({7'h0, scl_oe}, 8'h01, "scl held asleep");
    apb(1'b1, tws_pkg::OFF_CTRL, 8'hC4);
    check({6'h0, wake_req, scl_oe}, 8'h00, "released");
    sleep_deep <= 1'b0;
    m.stop();
    check({7'h0, stall_err}, 8'h00, "stretch bound");
    $display("test sleep done");
    results();
  end
endmodule
